/* File: shared/mcr_pkg.sv */
/*
 Constants for the metering calibration and control register bank:
 register indices, field positions, reset values and timing counts.
 Assumes a 50 MHz system clock and 32-bit AXI4-Lite register access.
*/
package mcr_pkg;
   localparam longint CLK_HZ = 50_000_000;

   // Register index; byte address is four times the index
   localparam logic [5:0] IDX_A_RMS_OFF = 6'h0E;
   localparam logic [5:0] IDX_B_RMS_OFF = 6'h0F;
   localparam logic [5:0] IDX_B_GAIN = 6'h10;
   localparam logic [5:0] IDX_CPW_LOW = 6'h11;
   localparam logic [5:0] IDX_CPW_HIGH = 6'h12;
   localparam logic [5:0] IDX_CTRL_TWO = 6'h17;
   localparam logic [5:0] IDX_ENERGY_ACC = 6'h2B;
   localparam logic [5:0] IDX_ENERGY_SEC = 6'h2C;
   localparam logic [5:0] IDX_DC_U = 6'h30;
   localparam logic [5:0] IDX_DC_A = 6'h31;
   localparam logic [5:0] IDX_DC_B = 6'h32;
   localparam logic [5:0] IDX_CPW_VALUE = 6'h33;

   localparam logic [15:0] RST_TRIM = 16'h0000;
   localparam logic [15:0] RST_CPW = 16'h0000;
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [19:0] RST_DC = 20'h00000;

   // Control word fields; reserved bits 15:14, 11:10 and 3:0 are held at zero
   localparam logic [15:0] CTL_WMASK = 16'h33F0;
   localparam int CTL_FREQ_LO = 12;
   localparam int CTL_PHB_LSB = 9;
   localparam int CTL_PHA_LSB = 8;
   localparam int CTL_RATE = 7;
   localparam int CTL_ZX = 6;
   localparam int CTL_SRC_LO = 4;

   localparam logic [5:0] FREQ_CYC_00 = 6'h20;
   localparam logic [5:0] FREQ_CYC_01 = 6'h04;
   localparam logic [5:0] FREQ_CYC_10 = 6'h08;
   localparam logic [5:0] FREQ_CYC_11 = 6'h10;

   typedef enum logic [1:0] {
      SRC_REACTIVE = 2'b00,
      SRC_SUM_AB = 2'b01,
      SRC_CUSTOM = 2'b10,
      SRC_ACTIVE_B = 2'b11
   } mcr_src_t;

   // Refresh rates in milli-hertz and their periods in clock cycles
   localparam longint REFRESH_SLOW_MHZ = 3495;
   localparam longint REFRESH_FAST_MHZ = 13982;
   localparam int REFRESH_SLOW_CYC = int'(CLK_HZ * 1000 / REFRESH_SLOW_MHZ);
   localparam int REFRESH_FAST_CYC = int'(CLK_HZ * 1000 / REFRESH_FAST_MHZ);

   localparam int GAIN_SHIFT = 15;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* File: verilog/mcr_trim.sv */
/*
 Combinational trim datapath: RMS offsets, channel-B gain correction and
 the three DC-offset corrections. Assumes its caller registers the results.
*/
`timescale 1ns/1ps
module mcr_trim import mcr_pkg::*; (
   input wire logic [23:0] rms_a_raw,
   input wire logic [23:0] rms_b_raw,
   input wire logic [15:0] a_rms_off,
   input wire logic [15:0] b_rms_off,
   input wire logic [23:0] current_b_raw,
   input wire logic [15:0] b_gain,
   input wire logic hpf_disabled,
   input wire logic [23:0] adc_u_raw,
   input wire logic [23:0] adc_a_raw,
   input wire logic [23:0] adc_b_raw,
   input wire logic [19:0] dc_u,
   input wire logic [19:0] dc_a,
   input wire logic [19:0] dc_b,
   output logic [23:0] rms_a_corr,
   output logic [23:0] rms_b_corr,
   output logic [23:0] current_b_corr,
   output logic [23:0] adc_u_corr,
   output logic [23:0] adc_a_corr,
   output logic [23:0] adc_b_corr
);
   logic signed [39:0] gain_prod;
   logic [23:0] adc_in [3];
   logic [19:0] dc_off [3];
   logic [23:0] adc_out [3];

   // Offsets are sign-extended two's complement
   assign rms_a_corr = rms_a_raw + {{8{a_rms_off[15]}}, a_rms_off};
   assign rms_b_corr = rms_b_raw + {{8{b_rms_off[15]}}, b_rms_off};

   // Gain is a signed fraction of 2^15, so the shift is the normalisation
   assign gain_prod = $signed(current_b_raw) * $signed(b_gain);
   assign current_b_corr = current_b_raw + gain_prod[GAIN_SHIFT+23:GAIN_SHIFT];

   assign adc_in[0] = adc_u_raw;
   assign adc_in[1] = adc_a_raw;
   assign adc_in[2] = adc_b_raw;
   assign dc_off[0] = dc_u;
   assign dc_off[1] = dc_a;
   assign dc_off[2] = dc_b;
   for (genvar c = 0; c < 3; c++) begin : g_dc
      assign adc_out[c] = hpf_disabled ? adc_in[c] - {{4{dc_off[c][19]}}, dc_off[c]} : adc_in[c];
   end
   assign adc_u_corr = adc_out[0];
   assign adc_a_corr = adc_out[1];
   assign adc_b_corr = adc_out[2];
endmodule

/* File: verilog/mcr_regs.sv */
/*
 Metering calibration and control register bank with an AXI4-Lite slave,
 trim outputs, custom energy integration and refresh timing.
 Assumes measurement data and sample_stb are synchronous to mclk.
*/
// What this block does
// - Hold and apply per-channel current RMS offsets
// - RMS offsets are two's complement, bit 15 sign
// - Channel-B gain normalised to signed fraction
// - Corrected B current equals raw plus raw-times-gain
// - Custom power is signed high:low 32 bits
// - Custom power source integrates, counts energy, pulses
// - Three 20-bit DC offsets when filter off
// - Bits 13:12 pick frequency period 32/4/8/16
// - Bit 9 is extra phase-B trim LSB
// - Bit 8 is extra phase-A trim LSB
// - Bit 7 picks refresh 3.495 or 13.982 Hz
// - Bit 6 picks raw or filtered zero-cross source
// - Bits 5:4 pick custom energy source
// - Source code 11 selects channel-B active power
`timescale 1ns/1ps
module mcr_regs import mcr_pkg::*; #(
   parameter int REFRESH_SLOW = REFRESH_SLOW_CYC,
   parameter int REFRESH_FAST = REFRESH_FAST_CYC
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sample_stb,
   input wire logic [23:0] rms_a_raw,
   input wire logic [23:0] rms_b_raw,
   input wire logic [23:0] current_b_raw,
   input wire logic hpf_disabled,
   input wire logic [23:0] adc_u_raw,
   input wire logic [23:0] adc_a_raw,
   input wire logic [23:0] adc_b_raw,
   input wire logic [23:0] volt_raw,
   input wire logic [23:0] volt_lpf,
   input wire logic [31:0] reactive_power,
   input wire logic [31:0] active_a_power,
   input wire logic [31:0] active_b_power,
   input wire logic [31:0] pulse_const,
   input wire logic [7:0] phase_a_trim,
   input wire logic [7:0] phase_b_trim,
   output logic [23:0] rms_a_out,
   output logic [23:0] rms_b_out,
   output logic [23:0] current_b_out,
   output logic [23:0] adc_u_out,
   output logic [23:0] adc_a_out,
   output logic [23:0] adc_b_out,
   output logic [5:0] frequency_period_cycles,
   output logic [8:0] phase_a_fine,
   output logic [8:0] phase_b_fine,
   output logic refresh_rate_select,
   output logic refresh_tick,
   output logic [23:0] zero_cross_sample,
   output logic secondary_pulse_output
);
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic aw_full_reg, w_full_reg;
   logic [5:0] aw_idx_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [15:0] a_rms_off_reg, b_rms_off_reg, b_gain_reg;
   logic [15:0] cpw_low_reg, cpw_high_reg, ctrl_reg;
   logic hi_pending_reg;
   logic [31:0] custom_power_value_reg;
   logic [19:0] dc_u_reg, dc_a_reg, dc_b_reg;
   logic signed [33:0] energy_acc_reg;
   logic [31:0] custom_energy_accumulator_reg, custom_energy_second_reg;
   logic pulse_reg;
   logic [23:0] refresh_cnt_reg;
   logic tick_reg;
   logic [23:0] rms_a_reg, rms_b_reg, ib_reg, adc_u_reg, adc_a_reg, adc_b_reg, zx_reg;
   logic [5:0] freq_reg;
   logic [8:0] pha_reg, phb_reg;

   wire aw_take = s_axi_awvalid & awready_reg;
   wire w_take = s_axi_wvalid & wready_reg;
   wire ar_take = s_axi_arvalid & arready_reg;
   wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
   wire [5:0] rd_idx = s_axi_araddr[7:2];
   wire [31:0] bit_en = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   wire [31:0] wnew = wdata_reg & bit_en;
   wire we_a_off = do_write && aw_idx_reg == IDX_A_RMS_OFF;
   wire we_b_off = do_write && aw_idx_reg == IDX_B_RMS_OFF;
   wire we_gain = do_write && aw_idx_reg == IDX_B_GAIN;
   wire we_low = do_write && aw_idx_reg == IDX_CPW_LOW;
   wire we_high = do_write && aw_idx_reg == IDX_CPW_HIGH;
   wire we_ctrl = do_write && aw_idx_reg == IDX_CTRL_TWO;
   wire we_dc_u = do_write && aw_idx_reg == IDX_DC_U;
   wire we_dc_a = do_write && aw_idx_reg == IDX_DC_A;
   wire we_dc_b = do_write && aw_idx_reg == IDX_DC_B;
   wire wr_ro = aw_idx_reg == IDX_ENERGY_ACC || aw_idx_reg == IDX_ENERGY_SEC || aw_idx_reg == IDX_CPW_VALUE;
   wire wr_ok = we_a_off | we_b_off | we_gain | we_low | we_high | we_ctrl | we_dc_u | we_dc_a | we_dc_b | wr_ro;
   wire [15:0] low16_next = (cpw_low_reg & ~bit_en[15:0]) | wnew[15:0];
   wire [15:0] ctrl_next = ((ctrl_reg & ~bit_en[15:0]) | wnew[15:0]) & CTL_WMASK;
   wire rd_sec = ar_take && rd_idx == IDX_ENERGY_SEC;

   // Byte-lane merge for a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] en, input logic [31:0] nw);
      merge16 = (old & ~en[15:0]) | nw[15:0];
   endfunction

   function automatic logic [19:0] merge20(input logic [19:0] old, input logic [31:0] en, input logic [31:0] nw);
      merge20 = (old & ~en[19:0]) | nw[19:0];
   endfunction

   // AXI4-Lite write channel; address and data may arrive in either order
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         aw_idx_reg <= 6'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_full_reg <= 1'b1;
            awready_reg <= 1'b0;
            aw_idx_reg <= s_axi_awaddr[7:2];
         end
         if (w_take) begin
            w_full_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   logic [31:0] rdata_next;
   // Read channel; one cycle from address to data
   always_comb begin
      case (rd_idx)
         IDX_A_RMS_OFF: rdata_next = {16'h0000, a_rms_off_reg};
         IDX_B_RMS_OFF: rdata_next = {16'h0000, b_rms_off_reg};
         IDX_B_GAIN: rdata_next = {16'h0000, b_gain_reg};
         IDX_CPW_LOW: rdata_next = {16'h0000, cpw_low_reg};
         IDX_CPW_HIGH: rdata_next = {16'h0000, cpw_high_reg};
         IDX_CTRL_TWO: rdata_next = {16'h0000, ctrl_reg};
         IDX_ENERGY_ACC: rdata_next = custom_energy_accumulator_reg;
         IDX_ENERGY_SEC: rdata_next = custom_energy_second_reg;
         IDX_DC_U: rdata_next = {12'h000, dc_u_reg};
         IDX_DC_A: rdata_next = {12'h000, dc_a_reg};
         IDX_DC_B: rdata_next = {12'h000, dc_b_reg};
         IDX_CPW_VALUE: rdata_next = custom_power_value_reg;
         default: rdata_next = 32'h00000000;
      endcase
   end
   wire rd_hit = rdata_ok(rd_idx);

   function automatic logic rdata_ok(input logic [5:0] i);
      rdata_ok = (i >= IDX_A_RMS_OFF && i <= IDX_CPW_HIGH) || i == IDX_CTRL_TWO || i == IDX_ENERGY_ACC
         || i == IDX_ENERGY_SEC || (i >= IDX_DC_U && i <= IDX_CPW_VALUE);
   endfunction

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_take) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= rdata_next;
         rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // Register file
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         a_rms_off_reg <= RST_TRIM;
         b_rms_off_reg <= RST_TRIM;
         b_gain_reg <= RST_TRIM;
         cpw_low_reg <= RST_CPW;
         cpw_high_reg <= RST_CPW;
         ctrl_reg <= RST_CTRL;
         dc_u_reg <= RST_DC;
         dc_a_reg <= RST_DC;
         dc_b_reg <= RST_DC;
      end else begin
         if (we_a_off) a_rms_off_reg <= merge16(a_rms_off_reg, bit_en, wnew);
         if (we_b_off) b_rms_off_reg <= merge16(b_rms_off_reg, bit_en, wnew);
         if (we_gain) b_gain_reg <= merge16(b_gain_reg, bit_en, wnew);
         if (we_low) cpw_low_reg <= low16_next;
         if (we_high) cpw_high_reg <= merge16(cpw_high_reg, bit_en, wnew);
         if (we_ctrl) ctrl_reg <= ctrl_next;
         if (we_dc_u) dc_u_reg <= merge20(dc_u_reg, bit_en, wnew);
         if (we_dc_a) dc_a_reg <= merge20(dc_a_reg, bit_en, wnew);
         if (we_dc_b) dc_b_reg <= merge20(dc_b_reg, bit_en, wnew);
      end
   end

   // The 32-bit value changes only on a low write that follows a high write,
   // so the integrator never sees a torn half-updated value
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hi_pending_reg <= 1'b0;
         custom_power_value_reg <= {RST_CPW, RST_CPW};
      end else if (we_high) begin
         hi_pending_reg <= 1'b1;
      end else if (we_low) begin
         hi_pending_reg <= 1'b0;
         if (hi_pending_reg) custom_power_value_reg <= {cpw_high_reg, low16_next};
      end
   end

   // Custom energy integration
   wire [1:0] src_sel = ctrl_reg[CTL_SRC_LO+1:CTL_SRC_LO];
   wire [33:0] ext_q = {{2{reactive_power[31]}}, reactive_power};
   wire [33:0] ext_a = {{2{active_a_power[31]}}, active_a_power};
   wire [33:0] ext_b = {{2{active_b_power[31]}}, active_b_power};
   wire [33:0] ext_c = {{2{custom_power_value_reg[31]}}, custom_power_value_reg};
   wire [33:0] ext_pc = {2'b00, pulse_const};
   wire [33:0] sel_power = src_sel == SRC_REACTIVE ? ext_q :
      src_sel == SRC_SUM_AB ? ext_a + ext_b :
      src_sel == SRC_CUSTOM ? ext_c : ext_b;
   wire signed [33:0] acc_sum = energy_acc_reg + $signed(sel_power);
   wire pos_fire = pulse_const != 32'h00000000 && acc_sum >= $signed(ext_pc);
   wire neg_fire = pulse_const != 32'h00000000 && acc_sum <= -$signed(ext_pc);
   wire fire = sample_stb && (pos_fire || neg_fire);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         energy_acc_reg <= 34'sh000000000;
         pulse_reg <= 1'b0;
         custom_energy_accumulator_reg <= 32'h00000000;
         custom_energy_second_reg <= 32'h00000000;
      end else begin
         pulse_reg <= fire;
         if (sample_stb) begin
            energy_acc_reg <= pos_fire ? acc_sum - $signed(ext_pc) : neg_fire ? acc_sum + $signed(ext_pc) : acc_sum;
         end
         if (fire) custom_energy_accumulator_reg <= custom_energy_accumulator_reg + 32'h00000001;
         // A pulse in the cycle of a clearing read is kept, not lost
         if (fire) begin
            custom_energy_second_reg <= rd_sec ? 32'h00000001 : custom_energy_second_reg + 32'h00000001;
         end else if (rd_sec) begin
            custom_energy_second_reg <= 32'h00000000;
         end
      end
   end

   // Refresh timer; a rate change takes effect within the current period
   wire [23:0] refresh_limit = ctrl_reg[CTL_RATE] ? 24'(REFRESH_FAST - 1) : 24'(REFRESH_SLOW - 1);
   wire refresh_end = refresh_cnt_reg >= refresh_limit;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         refresh_cnt_reg <= 24'h000000;
         tick_reg <= 1'b0;
      end else begin
         refresh_cnt_reg <= refresh_end ? 24'h000000 : refresh_cnt_reg + 24'h000001;
         tick_reg <= refresh_end;
      end
   end

   logic [23:0] rms_a_w, rms_b_w, ib_w, adc_u_w, adc_a_w, adc_b_w;

   mcr_trim u_trim (
      .rms_a_raw(rms_a_raw),
      .rms_b_raw(rms_b_raw),
      .a_rms_off(a_rms_off_reg),
      .b_rms_off(b_rms_off_reg),
      .current_b_raw(current_b_raw),
      .b_gain(b_gain_reg),
      .hpf_disabled(hpf_disabled),
      .adc_u_raw(adc_u_raw),
      .adc_a_raw(adc_a_raw),
      .adc_b_raw(adc_b_raw),
      .dc_u(dc_u_reg),
      .dc_a(dc_a_reg),
      .dc_b(dc_b_reg),
      .rms_a_corr(rms_a_w),
      .rms_b_corr(rms_b_w),
      .current_b_corr(ib_w),
      .adc_u_corr(adc_u_w),
      .adc_a_corr(adc_a_w),
      .adc_b_corr(adc_b_w)
   );

   wire [1:0] freq_code = ctrl_reg[CTL_FREQ_LO+1:CTL_FREQ_LO];
   wire [5:0] freq_next = freq_code == 2'b00 ? FREQ_CYC_00 : freq_code == 2'b01 ? FREQ_CYC_01 :
      freq_code == 2'b10 ? FREQ_CYC_10 : FREQ_CYC_11;

   // Output stage; RMS results move only on a refresh tick
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rms_a_reg <= 24'h000000;
         rms_b_reg <= 24'h000000;
         ib_reg <= 24'h000000;
         adc_u_reg <= 24'h000000;
         adc_a_reg <= 24'h000000;
         adc_b_reg <= 24'h000000;
         zx_reg <= 24'h000000;
         freq_reg <= FREQ_CYC_00;
         pha_reg <= 9'h000;
         phb_reg <= 9'h000;
      end else begin
         if (refresh_end) begin
            rms_a_reg <= rms_a_w;
            rms_b_reg <= rms_b_w;
         end
         if (sample_stb) begin
            ib_reg <= ib_w;
            adc_u_reg <= adc_u_w;
            adc_a_reg <= adc_a_w;
            adc_b_reg <= adc_b_w;
         end
         zx_reg <= ctrl_reg[CTL_ZX] ? volt_lpf : volt_raw;
         freq_reg <= freq_next;
         pha_reg <= {phase_a_trim, ctrl_reg[CTL_PHA_LSB]};
         phb_reg <= {phase_b_trim, ctrl_reg[CTL_PHB_LSB]};
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign rms_a_out = rms_a_reg;
   assign rms_b_out = rms_b_reg;
   assign current_b_out = ib_reg;
   assign adc_u_out = adc_u_reg;
   assign adc_a_out = adc_a_reg;
   assign adc_b_out = adc_b_reg;
   assign frequency_period_cycles = freq_reg;
   assign phase_a_fine = pha_reg;
   assign phase_b_fine = phb_reg;
   assign refresh_rate_select = ctrl_reg[CTL_RATE];
   assign refresh_tick = tick_reg;
   assign zero_cross_sample = zx_reg;
   assign secondary_pulse_output = pulse_reg;

   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_ctrl_write(logic [1:0] code);
      we_ctrl && wnew[CTL_FREQ_LO+1:CTL_FREQ_LO] == code && bit_en[CTL_FREQ_LO] && bit_en[CTL_FREQ_LO+1];
   endsequence

   a_cpv_commit: assert property (we_low && hi_pending_reg && !we_high |=>
      custom_power_value_reg == {cpw_high_reg, cpw_low_reg}) else $error("custom power not committed");
   a_cpv_order: assert property (we_low && !hi_pending_reg |=> $stable(custom_power_value_reg))
      else $error("custom power changed without high write");
   a_freq_period: assert property (s_ctrl_write(2'b01) |=> ##1 frequency_period_cycles == 6'h04)
      else $error("frequency period not four cycles");
   a_phase_a_fine: assert property (##1 phase_a_fine == {$past(phase_a_trim), $past(ctrl_reg[CTL_PHA_LSB])})
      else $error("phase A fine trim wrong");
   a_phase_b_fine: assert property (##1 phase_b_fine[0] == $past(ctrl_reg[CTL_PHB_LSB]))
      else $error("phase B extra bit wrong");
   // A rate change may leave the count above the new period for one cycle
   a_refresh_bound: assert property ($stable(ctrl_reg[CTL_RATE]) |->
      refresh_cnt_reg < (ctrl_reg[CTL_RATE] ? 24'(REFRESH_FAST) : 24'(REFRESH_SLOW)))
      else $error("refresh counter beyond period");
   a_zero_cross: assert property (ctrl_reg[CTL_ZX] && $stable(ctrl_reg) |=> zero_cross_sample == $past(volt_lpf))
      else $error("zero cross source not filtered signal");
   a_src_active_b: assert property (src_sel == 2'b11 && sample_stb && pulse_const == 32'h00000000 |=>
      energy_acc_reg == $past(energy_acc_reg) + $signed($past(ext_b))) else $error("source 11 not channel B");
   a_pulse_cause: assert property (secondary_pulse_output |-> $past(sample_stb))
      else $error("pulse without sample");
   a_gain_minus_one: assert property (sample_stb && b_gain_reg == 16'h8000 |=> current_b_out == 24'h000000)
      else $error("gain of minus one not cancelling");
   a_rms_offset: assert property (refresh_end |=>
      rms_a_out == 24'($past(rms_a_raw) + {{8{$past(a_rms_off_reg[15])}}, $past(a_rms_off_reg)}))
      else $error("RMS offset not applied");
   a_dc_bypass: assert property (sample_stb && !hpf_disabled |=> adc_u_out == $past(adc_u_raw))
      else $error("DC offset applied with filter on");
endmodule

/* File: test/tb.sv */
/* Self-checking testbench for mcr_regs, driven over AXI4-Lite.
 Assumes mcr_pkg is compiled first; refresh periods are shortened to 20 and 5 cycles. */
`timescale 1ns/1ps
module tb import mcr_pkg::*;;
   logic mclk = 0, rstn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, sample_stb = 0;
   logic s_axi_bready = 1, s_axi_rready = 1, hpf_disabled = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, phase_a_trim = 0, phase_b_trim = 0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 0, reactive_power = 0, active_a_power = 0, active_b_power = 0, pulse_const = 0;
   logic [23:0] rms_a_raw = 0, rms_b_raw = 0, current_b_raw = 0, adc_u_raw = 0, adc_a_raw = 0, adc_b_raw = 0;
   logic [23:0] volt_raw = 0, volt_lpf = 0, rms_a_out, rms_b_out, current_b_out, adc_u_out, adc_a_out, adc_b_out;
   logic [23:0] zero_cross_sample;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic refresh_rate_select, refresh_tick, secondary_pulse_output;
   logic [5:0] frequency_period_cycles;
   logic [8:0] phase_a_fine, phase_b_fine;
   logic [5:0] fp [4] = '{6'h20, 6'h04, 6'h08, 6'h10};
   int error_cnt = 0, checked = 0;
   always #10 mclk = ~mclk;
   mcr_regs #(.REFRESH_SLOW(20), .REFRESH_FAST(5)) uut (
      .mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_stb, .rms_a_raw, .rms_b_raw,
      .current_b_raw, .hpf_disabled, .adc_u_raw, .adc_a_raw, .adc_b_raw, .volt_raw, .volt_lpf, .reactive_power,
      .active_a_power, .active_b_power, .pulse_const, .phase_a_trim, .phase_b_trim, .rms_a_out, .rms_b_out,
      .current_b_out, .adc_u_out, .adc_a_out, .adc_b_out, .frequency_period_cycles, .phase_a_fine,
      .phase_b_fine, .refresh_rate_select, .refresh_tick, .zero_cross_sample, .secondary_pulse_output
   );
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic guard(input int n);
      if (n >= 99) begin
         error_cnt++;
         final_report;
      end
   endtask
   // Valid and payload stay up until each channel's own ready is seen
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 99);
      guard(n);
      chk("bresp", 32'(s_axi_bresp), 32'(r));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 99);
      guard(n);
      chk("rdata", s_axi_rdata, e);
      chk("rresp", 32'(s_axi_rresp), 32'(r));
   endtask
   task automatic stb;
      sample_stb <= 1'b1;
      @(posedge mclk);
      sample_stb <= 1'b0;
      @(posedge mclk);
   endtask
   initial begin
      int n;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      chk("freq", 32'(frequency_period_cycles), 32'h20);
      rd(8'h3C, 0, RESP_OKAY);
      rd(8'h40, 0, RESP_OKAY);
      rd(8'h5C, 0, RESP_OKAY);
      wr(8'h00, 0, RESP_SLVERR);
      rd(8'h00, 0, RESP_SLVERR);
      $display("test reset done");
      wr(8'h38, 32'hFFFF, RESP_OKAY);
      rd(8'h38, 32'hFFFF, RESP_OKAY);
      wr(8'h40, 32'hC000, RESP_OKAY);
      wr(8'hC4, 32'h5, RESP_OKAY);
      wr(8'hC8, 32'hFFFFE, RESP_OKAY);
      rms_a_raw <= 24'd100;
      rms_b_raw <= 24'd7;
      adc_u_raw <= 24'd3;
      adc_b_raw <= 24'd4;
      current_b_raw <= 24'd256;
      adc_a_raw <= 24'd20;
      hpf_disabled <= 1'b1;
      stb();
      repeat (2) @(posedge mclk);
      chk("current_b", 32'(current_b_out), 32'd128);
      chk("adc_a", 32'(adc_a_out), 32'd15);
      chk("adc_b", 32'(adc_b_out), 32'd6);
      chk("adc_u", 32'(adc_u_out), 32'd3);
      n = 0;
      while (!refresh_tick && n < 99) begin
         @(posedge mclk);
         n++;
      end
      guard(n);
      repeat (2) @(posedge mclk);
      chk("rms_a", 32'(rms_a_out), 32'd99);
      chk("rms_b", 32'(rms_b_out), 32'd7);
      $display("test trims done");
      for (int k = 0; k < 4; k++) begin
         wr(8'h5C, {18'h0, k[1:0], 12'hFEF}, RESP_OKAY);
         rd(8'h5C, {18'h0, k[1:0], 12'h3E0}, RESP_OKAY);
         chk("freq", 32'(frequency_period_cycles), 32'(fp[k]));
      end
      phase_a_trim <= 8'h12;
      phase_b_trim <= 8'h34;
      volt_lpf <= 24'd5;
      volt_raw <= 24'd9;
      repeat (3) @(posedge mclk);
      chk("phase_a", 32'(phase_a_fine), 32'h25);
      chk("phase_b", 32'(phase_b_fine), 32'h69);
      chk("rate", 32'(refresh_rate_select), 32'h1);
      chk("zero_cross", 32'(zero_cross_sample), 32'd5);
      $display("test control done");
      wr(8'h44, 32'h1111, RESP_OKAY);
      rd(8'hCC, 0, RESP_OKAY);
      wr(8'h48, 32'h8000, RESP_OKAY);
      wr(8'h44, 32'h0002, RESP_OKAY);
      rd(8'hCC, 32'h80000002, RESP_OKAY);
      wr(8'h5C, 32'h30, RESP_OKAY);
      hpf_disabled <= 1'b0;
      active_b_power <= 32'd10;
      stb();
      chk("pulse", 32'(secondary_pulse_output), 32'h0);
      chk("zero_cross", 32'(zero_cross_sample), 32'd9);
      chk("rate", 32'(refresh_rate_select), 32'h0);
      chk("adc_a", 32'(adc_a_out), 32'd20);
      pulse_const <= 32'd10;
      stb();
      chk("pulse", 32'(secondary_pulse_output), 32'h1);
      rd(8'hAC, 1, RESP_OKAY);
      rd(8'hB0, 1, RESP_OKAY);
      rd(8'hB0, 0, RESP_OKAY);
      // Sum of -20 and 10 cancels the 10 left in the accumulator; either input alone would pulse
      wr(8'h5C, 32'h10, RESP_OKAY);
      active_a_power <= 32'hFFFFFFEC;
      stb();
      chk("pulse", 32'(secondary_pulse_output), 32'h0);
      stb();
      chk("pulse", 32'(secondary_pulse_output), 32'h1);
      wr(8'h5C, 32'h00, RESP_OKAY);
      active_a_power <= 32'h00000000;
      active_b_power <= 32'h00000000;
      reactive_power <= 32'd10;
      stb();
      chk("pulse", 32'(secondary_pulse_output), 32'h1);
      wr(8'h5C, 32'h20, RESP_OKAY);
      stb();
      chk("pulse", 32'(secondary_pulse_output), 32'h1);
      rd(8'hAC, 4, RESP_OKAY);
      $display("test energy done");
      final_report;
   end
endmodule
